// file: logic/mag_core.sv
// Address generation, bus strobes, stack pointer and dual data pointers
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
module mag_core #(
  parameter int SLOW_MULT = mag_pkg::MAG_MULT_DIV11
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic acc_req_i,
  input wire logic acc_move_i,
  input wire logic acc_write_i,
  input wire logic acc_internal_i,
  input wire logic [21:0] fetch_addr_i,
  input wire logic [7:0] acc_wdata_i,
  output logic acc_busy_o,
  output logic acc_done_o,
  output logic [7:0] acc_rdata_o,
  output logic [3:0] move_cycles_o,
  input wire logic inc_pointer_i,
  input wire logic inc_select_i,
  output logic [15:0] active_pointer_o,
  output logic [9:0] stack_addr_o,
  output logic stack_in_data_mem_o,
  output logic [7:0] port_four_o,
  output logic [7:0] port_four_oe_o,
  input wire logic [7:0] port_four_i,
  output logic [7:0] port_zero_o,
  output logic port_zero_oe_o,
  input wire logic [7:0] port_zero_i,
  output logic [7:0] port_one_o,
  output logic [7:0] port_two_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic psen_n_o,
  output logic [3:0] peripheral_enables_n_o
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] sp_low;
    logic [7:0] sp_high;
    logic [7:0] p4_cfg;
    logic [7:0] mem_ctrl;
    logic stack_mode;
    logic [7:0] clk_ctrl;
    logic [7:0] ptr_sel;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [7:0] p4_data;
    logic ack;
    logic [7:0] rdat;
    mag_pkg::mag_state_t st;
    logic [16:0] cnt;
    logic [5:0] lat_cfg;
    logic lat_demux;
    logic [21:0] addr;
    logic move;
    logic write;
    logic [7:0] wdata;
    logic [7:0] rdval;
    logic done;
    logic [3:0] moves;
  } mag_regs_t;

  mag_regs_t r;
  mag_regs_t next_r;

  logic bus_req;
  logic bus_wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic sel;
  logic [15:0] act_ptr;
  logic [3:0] addr_en;
  logic [3:0] ce_en;
  logic [1:0] ce_idx;
  logic [16:0] strobe_len;

  // Strobe width in core clocks for a stretch count and clock mode
  function automatic logic [16:0] calc_len(input logic [2:0] c, input logic [1:0] dv,
                                           input logic dbl);
    logic [16:0] mult;
    mult = 17'(mag_pkg::MAG_MULT_NORM);
    if (dv == 2'b11) begin
      mult = 17'(SLOW_MULT);
    end else if (dv == 2'b10) begin
      mult = 17'(mag_pkg::MAG_MULT_DIV10);
    end else if (dbl && dv == 2'b00) begin
      mult = 17'(mag_pkg::MAG_MULT_DBL);
    end
    if (c == 3'h0) begin
      calc_len = mult >> 1;
    end else begin
      calc_len = 17'(mult * 17'(c));
    end
  endfunction

  // Machine cycles per move; the jump after count three is the real cost
  function automatic logic [3:0] calc_moves(input logic [2:0] c);
    calc_moves = (c[2]) ? 4'(c) + 4'h5 : 4'(c) + 4'h2;
  endfunction

  // Field decode for one three-bit config field: 1xx enables xx+1 lines from bit 0
  function automatic logic [3:0] calc_en(input logic [2:0] f);
    calc_en = f[2] ? 4'((5'h2 << f[1:0]) - 5'h1) : 4'h0;
  endfunction

  // ==========================================================
  // Decode helpers
  assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  assign sel = r.ptr_sel[mag_pkg::MAG_SEL_BIT];
  assign act_ptr = sel ? r.dp1 : r.dp0;
  assign addr_en = calc_en(r.lat_cfg[5:3]);
  assign ce_en = calc_en(r.lat_cfg[2:0]);
  assign ce_idx = r.addr[21:20];
  assign strobe_len = calc_len(r.mem_ctrl[2:0], r.clk_ctrl[7:6],
                               r.clk_ctrl[mag_pkg::MAG_DOUBLER_BIT]);

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.ack = bus_req;
    next_r.done = 1'b0;
    // Register writes; a bus write beats a same-cycle core update
    if (bus_wr) begin
      unique case (idx)
        mag_pkg::MAG_IDX_SP_LOW: next_r.sp_low = wbyte;
        mag_pkg::MAG_IDX_SP_HIGH: next_r.sp_high = wbyte;
        mag_pkg::MAG_IDX_P4_CFG: next_r.p4_cfg = wbyte;
        mag_pkg::MAG_IDX_MEM_CTRL: next_r.mem_ctrl = wbyte;
        mag_pkg::MAG_IDX_CLK_CTRL: next_r.clk_ctrl = wbyte;
        mag_pkg::MAG_IDX_P4_DATA: next_r.p4_data = wbyte;
        mag_pkg::MAG_IDX_PTR_SEL: next_r.ptr_sel = wbyte & mag_pkg::MAG_PTR_SEL_MASK;
        mag_pkg::MAG_IDX_DP0_LOW: next_r.dp0[7:0] = wbyte;
        mag_pkg::MAG_IDX_DP0_HIGH: next_r.dp0[15:8] = wbyte;
        mag_pkg::MAG_IDX_DP1_LOW: next_r.dp1[7:0] = wbyte;
        mag_pkg::MAG_IDX_DP1_HIGH: next_r.dp1[15:8] = wbyte;
        mag_pkg::MAG_IDX_ADDR_CTRL: begin
          // Shared SRAM mapping leaves no room for the big stack
          next_r.stack_mode = wbyte[mag_pkg::MAG_SA_BIT] &&
            (r.mem_ctrl[4:3] != mag_pkg::MAG_IDM_SHARED);
        end
        default: begin
        end
      endcase
    end
    // Mapping the SRAM as shared later also drops the big stack
    if (next_r.mem_ctrl[4:3] == mag_pkg::MAG_IDM_SHARED) begin
      next_r.stack_mode = 1'b0;
    end
    // Core pointer operations
    if (!bus_wr && inc_select_i) begin
      next_r.ptr_sel[mag_pkg::MAG_SEL_BIT] = !sel;
    end
    if (!bus_wr && inc_pointer_i) begin
      if (sel) begin
        next_r.dp1 = r.ptr_sel[mag_pkg::MAG_DIR1_BIT] ? r.dp1 - 16'h0001 :
          r.dp1 + 16'h0001;
      end else begin
        next_r.dp0 = r.ptr_sel[mag_pkg::MAG_DIR0_BIT] ? r.dp0 - 16'h0001 :
          r.dp0 + 16'h0001;
      end
    end
    // Register reads, unmapped answers zero
    next_r.rdat = 8'h00;
    if (bus_req && !wb_we_i) begin
      unique case (idx)
        mag_pkg::MAG_IDX_SP_LOW: next_r.rdat = r.sp_low;
        mag_pkg::MAG_IDX_SP_HIGH: next_r.rdat = r.sp_high;
        mag_pkg::MAG_IDX_P4_CFG: next_r.rdat = r.p4_cfg;
        mag_pkg::MAG_IDX_MEM_CTRL: next_r.rdat = r.mem_ctrl;
        mag_pkg::MAG_IDX_CLK_CTRL: next_r.rdat = r.clk_ctrl;
        mag_pkg::MAG_IDX_P4_DATA: next_r.rdat = port_four_i;
        mag_pkg::MAG_IDX_PTR_SEL: next_r.rdat = r.ptr_sel;
        mag_pkg::MAG_IDX_DP0_LOW: next_r.rdat = r.dp0[7:0];
        mag_pkg::MAG_IDX_DP0_HIGH: next_r.rdat = r.dp0[15:8];
        mag_pkg::MAG_IDX_DP1_LOW: next_r.rdat = r.dp1[7:0];
        mag_pkg::MAG_IDX_DP1_HIGH: next_r.rdat = r.dp1[15:8];
        mag_pkg::MAG_IDX_ADDR_CTRL: next_r.rdat = {5'h00, r.stack_mode, 2'h0};
        default: next_r.rdat = 8'h00;
      endcase
    end
    // Access sequencer; config is latched here so a write mid-access is harmless
    unique case (r.st)
      mag_pkg::MAG_IDLE: begin
        if (acc_req_i) begin
          next_r.move = acc_move_i;
          next_r.write = acc_write_i;
          next_r.wdata = acc_wdata_i;
          next_r.addr = acc_move_i ? {6'h00, act_ptr} : fetch_addr_i;
          if (acc_move_i && acc_internal_i) begin
            next_r.moves = calc_moves(3'h0);
            next_r.st = mag_pkg::MAG_FINISH;
          end else begin
            next_r.lat_cfg = r.p4_cfg[5:0];
            next_r.lat_demux = r.mem_ctrl[mag_pkg::MAG_DEMUX_BIT];
            next_r.moves = calc_moves(r.mem_ctrl[2:0]);
            next_r.cnt = acc_move_i ? strobe_len : 17'h00001;
            next_r.st = mag_pkg::MAG_ADDR;
          end
        end
      end
      mag_pkg::MAG_ADDR: begin
        next_r.st = mag_pkg::MAG_STROBE;
      end
      mag_pkg::MAG_STROBE: begin
        next_r.cnt = r.cnt - 17'h00001;
        if (r.cnt <= 17'h00001) begin
          next_r.rdval = port_zero_i;
          next_r.st = mag_pkg::MAG_FINISH;
        end
      end
      mag_pkg::MAG_FINISH: begin
        next_r.done = 1'b1;
        next_r.st = mag_pkg::MAG_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.p4_cfg <= mag_pkg::MAG_P4_CFG_RST;
      r.lat_cfg <= mag_pkg::MAG_P4_CFG_RST[5:0];
      r.mem_ctrl <= mag_pkg::MAG_MEM_CTRL_RST;
      r.sp_low <= mag_pkg::MAG_SP_LOW_RST;
      r.clk_ctrl <= mag_pkg::MAG_CLK_CTRL_RST;
      r.stack_mode <= 1'b0;
      r.p4_data <= 8'hff;
      r.st <= mag_pkg::MAG_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = r.ack;
  assign wb_dat_o = {24'h000000, r.rdat};
  assign acc_busy_o = (r.st != mag_pkg::MAG_IDLE);
  assign acc_done_o = r.done;
  assign acc_rdata_o = r.rdval;
  assign move_cycles_o = r.moves;
  assign active_pointer_o = act_ptr;
  // Small stack stays in scratchpad, big one in first 1kB of data memory
  assign stack_in_data_mem_o = r.stack_mode;
  assign stack_addr_o = r.stack_mode ? {r.sp_high[1:0], r.sp_low} : {2'h0, r.sp_low};

  // Bus pins: port zero carries low address only in multiplexed mode
  assign ale_o = (r.st == mag_pkg::MAG_ADDR);
  assign port_two_o = r.addr[15:8];
  assign port_one_o = r.lat_demux ? r.addr[7:0] : 8'h00;
  assign port_zero_o = (ale_o && !r.lat_demux) ? r.addr[7:0] : r.wdata;
  // Write data is driven only while the strobe is low, so a demultiplexed address phase
  // and an internal move leave port zero released
  assign port_zero_oe_o = (ale_o && !r.lat_demux) ||
                          (r.st == mag_pkg::MAG_STROBE && r.write && r.move);
  assign rd_n_o = !(r.st == mag_pkg::MAG_STROBE && r.move && !r.write);
  assign wr_n_o = !(r.st == mag_pkg::MAG_STROBE && r.move && r.write);
  assign psen_n_o = !(r.st == mag_pkg::MAG_STROBE && !r.move);

  // Port four per pin: address, chip enable or quasi I/O that only pulls low
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_p4
      logic ce_act;
      assign ce_act = acc_busy_o && !r.move && (ce_idx == 2'(gi)) &&
                      (r.st != mag_pkg::MAG_FINISH);
      assign port_four_o[gi + 4] = addr_en[gi] ? r.addr[16 + gi] : 1'b0;
      assign port_four_oe_o[gi + 4] = addr_en[gi] || !r.p4_data[gi + 4];
      assign port_four_o[gi] = ce_en[gi] ? !ce_act : 1'b0;
      assign port_four_oe_o[gi] = ce_en[gi] || !r.p4_data[gi];
      assign peripheral_enables_n_o[gi] = !(acc_busy_o && r.move && ce_idx == 2'(gi));
    end
  endgenerate

  // ==========================================================
  // Checks
  logic [16:0] chk_len;
  logic [16:0] chk_cnt;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chk_len <= 17'h00000;
      chk_cnt <= 17'h00000;
    end else if (r.st == mag_pkg::MAG_IDLE && acc_req_i && acc_move_i) begin
      chk_len <= strobe_len;
      chk_cnt <= 17'h00000;
    end else if (!rd_n_o || !wr_n_o) begin
      chk_cnt <= chk_cnt + 17'h00001;
    end
  end

  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_move_start;
    r.st == mag_pkg::MAG_IDLE && acc_req_i && acc_move_i && !acc_internal_i;
  endsequence
  sequence s_addr_phase;
    ale_o && rd_n_o && wr_n_o;
  endsequence

  move_addr_phase_a: assert property (s_move_start |=> s_addr_phase ##1 (!rd_n_o || !wr_n_o))
    else $error("move did not follow address phase with strobe");
  strobe_width_a: assert property ($rose(rd_n_o && wr_n_o) && r.move |-> chk_cnt == chk_len)
    else $error("strobe width differs from stretch setting");
  move_cycles_a: assert property (s_move_start ##1 1 |-> move_cycles_o ==
    ((r.mem_ctrl[2]) ? 4'(r.mem_ctrl[2:0]) + 4'h5 : 4'(r.mem_ctrl[2:0]) + 4'h2)
    || $changed(r.mem_ctrl))
    else $error("machine cycle count wrong");
  internal_move_a: assert property (r.st == mag_pkg::MAG_IDLE && acc_req_i && acc_move_i &&
    acc_internal_i |=> (rd_n_o && wr_n_o && move_cycles_o == 4'h2) [*2])
    else $error("internal move produced strobes");
  demux_pins_a: assert property (ale_o && r.lat_demux |-> port_one_o == r.addr[7:0] &&
    !port_zero_oe_o)
    else $error("demultiplexed address not on port one");
  addr_pins_a: assert property (r.lat_cfg[5:3] == 3'b111 && ale_o |->
    port_four_o[7:4] == r.addr[19:16])
    else $error("upper address lines wrong");
  ce_pins_a: assert property (ale_o && !r.move && r.lat_cfg[2:0] == 3'b111 |->
    port_four_o[ce_idx] == 1'b0)
    else $error("chip enable not asserted on fetch");
  stack_addr_a: assert property (r.stack_mode |-> stack_addr_o ==
    {r.sp_high[1:0], r.sp_low})
    else $error("extended stack address wrong");
  stack_shared_a: assert property (r.mem_ctrl[4:3] == mag_pkg::MAG_IDM_SHARED |->
    !stack_in_data_mem_o)
    else $error("big stack enabled with shared sram");
  select_toggle_a: assert property (inc_select_i && !bus_wr |=>
    r.ptr_sel == ($past(r.ptr_sel) ^ 8'h01))
    else $error("select increment disturbed other bits");
  inactive_keep_a: assert property (inc_pointer_i && !bus_wr && !sel |=>
    $stable(r.dp1) && r.dp0 != $past(r.dp0))
    else $error("pointer increment hit wrong pointer");
  done_pulse_a: assert property (acc_done_o |=> !acc_done_o)
    else $error("access done held longer than one cycle");
  fetch_strobe_a: assert property (ale_o && !r.move |=> !psen_n_o && rd_n_o && wr_n_o)
    else $error("fetch did not strobe program enable");
  gpio_release_a: assert property (!addr_en[0] && r.p4_data[4] |-> !port_four_oe_o[4])
    else $error("released port four pin still driven");
endmodule

// file: logic/mag_pkg.sv
// Constants and types shared by the memory address generation block
package mag_pkg;
  // ==========================================================
  // Register indexes (byte address on the bus is index times four)
  localparam logic [7:0] MAG_IDX_SP_LOW = 8'h81;
  localparam logic [7:0] MAG_IDX_DP0_LOW = 8'h82;
  localparam logic [7:0] MAG_IDX_DP0_HIGH = 8'h83;
  localparam logic [7:0] MAG_IDX_DP1_LOW = 8'h84;
  localparam logic [7:0] MAG_IDX_DP1_HIGH = 8'h85;
  localparam logic [7:0] MAG_IDX_PTR_SEL = 8'h86;
  localparam logic [7:0] MAG_IDX_CLK_CTRL = 8'h8e;
  localparam logic [7:0] MAG_IDX_P4_CFG = 8'h92;
  localparam logic [7:0] MAG_IDX_MEM_CTRL = 8'h96;
  localparam logic [7:0] MAG_IDX_SP_HIGH = 8'h9b;
  localparam logic [7:0] MAG_IDX_ADDR_CTRL = 8'h9d;
  localparam logic [7:0] MAG_IDX_P4_DATA = 8'ha5;
  // ==========================================================
  // Field positions
  localparam int MAG_P4_UPPER_LSB = 3;
  localparam int MAG_P4_LOWER_LSB = 0;
  localparam int MAG_STRETCH_LSB = 0;
  localparam int MAG_IDM_LSB = 3;
  localparam int MAG_DEMUX_BIT = 5;
  localparam int MAG_SA_BIT = 2;
  localparam int MAG_SEL_BIT = 0;
  localparam int MAG_DIR0_BIT = 6;
  localparam int MAG_DIR1_BIT = 7;
  localparam int MAG_DOUBLER_BIT = 3;
  localparam int MAG_CLKDIV_LSB = 6;
  localparam logic [7:0] MAG_PTR_SEL_MASK = 8'hc1;
  localparam logic [1:0] MAG_IDM_SHARED = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] MAG_P4_CFG_RST = 8'h3f;
  localparam logic [7:0] MAG_MEM_CTRL_RST = 8'h01;
  localparam logic [7:0] MAG_SP_LOW_RST = 8'h07;
  localparam logic [7:0] MAG_CLK_CTRL_RST = 8'h00;
  // ==========================================================
  // Timing: strobe units are half oscillator periods, one per core clock
  localparam int MAG_CLK_MHZ = 25;
  localparam int MAG_MULT_DBL = 2;
  localparam int MAG_MULT_NORM = 4;
  localparam int MAG_MULT_DIV10 = 8;
  localparam int MAG_MULT_DIV11 = 8192;
  // ==========================================================
  // Access sequencer states
  typedef enum logic [1:0] {
    MAG_IDLE = 2'b00,
    MAG_ADDR = 2'b01,
    MAG_STROBE = 2'b10,
    MAG_FINISH = 2'b11
  } mag_state_t;
endpackage

// file: tb/mag_mem_model.sv
// External memory partner: answers reads, records writes, pulls port four up
`timescale 1ns/1ns
module mag_mem_model (
  input wire logic core_clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic psen_n_i,
  input wire logic [7:0] addr_mid_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] p4_i,
  input wire logic [7:0] p4_oe_i,
  output logic [7:0] data_o,
  output logic [7:0] p4_o,
  output logic [7:0] last_wr_o
);
  logic [7:0] page = 8'h00;
  logic [7:0] last = 8'h00;
  // ==========================================================
  // Middle address byte latched at ale; read data is a pattern of it
  always @(posedge core_clk_i) begin
    if (ale_i) page <= addr_mid_i;
    if (!rd_n_i || !psen_n_i) last <= page ^ 8'h5a;
    if (!wr_n_i) last_wr_o <= data_i;
  end
  // Released bus shows the inverse of the last value, so stale data never matches
  always_comb begin
    data_o = (!rd_n_i || !psen_n_i) ? (page ^ 8'h5a) : ~last;
    p4_o = (p4_i & p4_oe_i) | ~p4_oe_i;
  end
endmodule

// file: tb/mag_core_tb_top.sv
// Self-checking bench for the memory address generation block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module mag_core_tb_top;
  localparam int SLOW = 16;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic acc_req_i = 1'b0, acc_move_i = 1'b0, acc_write_i = 1'b0, acc_internal_i = 1'b0;
  logic [21:0] fetch_addr_i = 22'h00_0000;
  logic [7:0] acc_wdata_i = 8'h00;
  logic inc_pointer_i = 1'b0, inc_select_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, acc_busy_o, acc_done_o, stack_in_data_mem_o, port_zero_oe_o;
  logic ale_o, rd_n_o, wr_n_o, psen_n_o;
  logic [7:0] acc_rdata_o, port_four_o, port_four_oe_o, port_four_i, port_zero_o, port_zero_i;
  logic [7:0] port_one_o, port_two_o, last_wr;
  logic [3:0] move_cycles_o, peripheral_enables_n_o;
  logic [15:0] active_pointer_o;
  logic [9:0] stack_addr_o;
  logic [31:0] seed = 32'h0021_9bb2;
  logic [7:0] rd_q[$];
  logic [3:0] cyc_q[$];
  logic [3:0] cyc_tab[8] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb, 4'hc};
  logic [7:0] clk_tab[4] = '{8'h08, 8'h00, 8'h80, 8'hc0};
  int mult_tab[4] = '{2, 4, 8, SLOW};
  int err_total = 0;
  int comparisons = 0;
  logic [3:0] hi_en = 4'hf;
  logic [3:0] lo_en = 4'hf;
  mag_core #(.SLOW_MULT(SLOW)) dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .acc_req_i(acc_req_i), .acc_move_i(acc_move_i), .acc_write_i(acc_write_i),
    .acc_internal_i(acc_internal_i), .fetch_addr_i(fetch_addr_i), .acc_wdata_i(acc_wdata_i),
    .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o), .acc_rdata_o(acc_rdata_o),
    .move_cycles_o(move_cycles_o), .inc_pointer_i(inc_pointer_i), .inc_select_i(inc_select_i),
    .active_pointer_o(active_pointer_o), .stack_addr_o(stack_addr_o),
    .stack_in_data_mem_o(stack_in_data_mem_o), .port_four_o(port_four_o),
    .port_four_oe_o(port_four_oe_o), .port_four_i(port_four_i), .port_zero_o(port_zero_o),
    .port_zero_oe_o(port_zero_oe_o), .port_zero_i(port_zero_i), .port_one_o(port_one_o),
    .port_two_o(port_two_o), .ale_o(ale_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .psen_n_o(psen_n_o), .peripheral_enables_n_o(peripheral_enables_n_o));
  mag_mem_model mem_u (.core_clk_i(core_clk_i), .ale_i(ale_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .psen_n_i(psen_n_o), .addr_mid_i(port_two_o), .data_i(port_zero_o),
    .p4_i(port_four_o), .p4_oe_i(port_four_oe_o), .data_o(port_zero_i),
    .p4_o(port_four_i), .last_wr_o(last_wr));
  // ==========================================================
  // Clock, random source and closing
  always #20 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Wishbone classic master: hold until ack, release at the ack edge
  task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    @(posedge core_clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1) err_total++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    rd_q.push_back(e);
    wb(idx, 1'b0, 8'h00);
  endtask
  // One-cycle core pulse: select toggle when s is high, pointer step otherwise
  task automatic pulse(input logic s);
    @(posedge core_clk_i);
    inc_select_i <= s;
    inc_pointer_i <= !s;
    @(posedge core_clk_i);
    inc_select_i <= 1'b0;
    inc_pointer_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  // Access request, then watch the bus cycle by cycle until done
  task automatic acc(input logic m, w, i, input logic [21:0] a, input logic [7:0] d,
      input int ns, input logic dm);
    int n;
    int s;
    n = 0;
    s = 0;
    @(posedge core_clk_i);
    acc_req_i <= 1'b1;
    acc_move_i <= m;
    acc_write_i <= w;
    acc_internal_i <= i;
    fetch_addr_i <= a;
    acc_wdata_i <= d;
    @(posedge core_clk_i);
    acc_req_i <= 1'b0;
    while (acc_done_o !== 1'b1 && n < 400) begin
      @(negedge core_clk_i);
      n++;
      if (rd_n_o === 1'b0 || wr_n_o === 1'b0 || psen_n_o === 1'b0) s++;
      if (ale_o === 1'b1) begin
        `CHK(port_two_o, a[15:8])
        `CHK(dm ? port_one_o : port_zero_o, a[7:0])
        `CHK(port_four_o[7:4], a[19:16] & hi_en)
        `CHK(port_zero_oe_o, !dm)
        `CHK(peripheral_enables_n_o, m ? 4'he : 4'hf)
      end
      if (psen_n_o === 1'b0) `CHK(port_four_o[3:0], ~(4'h1 << a[21:20]) & lo_en)
    end
    // Negedges are counted from the take edge up to and including the done cycle
    `CHK(n, i ? 2 : ns + 3)
    `CHK(s, ns)
    if (m && !w && !i) `CHK(acc_rdata_o, a[15:8] ^ 8'h5a)
    if (m && w && !i) `CHK(last_wr, d)
  endtask
  // Result watcher: oldest note against each answer as it appears
  always @(negedge core_clk_i) begin
    logic [7:0] eb;
    logic [3:0] ec;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
      eb = rd_q.pop_front();
      `CHK(wb_dat_o, {24'h00_0000, eb})
    end
    if (acc_done_o === 1'b1 && cyc_q.size() > 0) begin
      ec = cyc_q.pop_front();
      `CHK(move_cycles_o, ec)
    end
  end
  // Watchdog sized well above the longest expected run
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] p;
    logic [2:0] code[5];
    logic [3:0] msk[5];
    int ns;
    code = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    msk = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    acc(1'b0, 1'b0, 1'b0, 22'h00_0000, 8'h00, 1, 1'b0);
    rd(mag_pkg::MAG_IDX_P4_CFG, 8'h3f);
    rd(mag_pkg::MAG_IDX_MEM_CTRL, 8'h01);
    rd(mag_pkg::MAG_IDX_SP_LOW, 8'h07);
    rd(mag_pkg::MAG_IDX_ADDR_CTRL, 8'h00);
    rd(8'h80, 8'h00);
    `CHK(stack_in_data_mem_o, 1'b0)
    acc(1'b0, 1'b0, 1'b0, 22'h2a_bcde, 8'h00, 1, 1'b0);
    wb(mag_pkg::MAG_IDX_DP0_LOW, 1'b1, 8'h78);
    wb(mag_pkg::MAG_IDX_DP0_HIGH, 1'b1, 8'h56);
    cyc_q.push_back(4'h3);
    acc(1'b1, 1'b0, 1'b0, 22'h00_5678, 8'h00, 4, 1'b0);
    $display("test reset done");
    // Stretch count against every clock mode
    for (int k = 0; k < 4; k++) begin
      wb(mag_pkg::MAG_IDX_CLK_CTRL, 1'b1, clk_tab[k]);
      for (int s = 0; s < 8; s++) begin
        r = rnd();
        p = r[15:0];
        wb(mag_pkg::MAG_IDX_DP0_LOW, 1'b1, p[7:0]);
        wb(mag_pkg::MAG_IDX_DP0_HIGH, 1'b1, p[15:8]);
        wb(mag_pkg::MAG_IDX_MEM_CTRL, 1'b1, {5'h00, 3'(s)});
        ns = (s == 0) ? mult_tab[k] / 2 : s * mult_tab[k];
        cyc_q.push_back(cyc_tab[s]);
        acc(1'b1, 1'b0, 1'b0, {6'h00, p}, 8'h00, ns, 1'b0);
      end
    end
    $display("test stretch done");
    wb(mag_pkg::MAG_IDX_CLK_CTRL, 1'b1, 8'h00);
    wb(mag_pkg::MAG_IDX_MEM_CTRL, 1'b1, 8'h21);
    cyc_q.push_back(4'h3);
    acc(1'b1, 1'b0, 1'b0, {6'h00, p}, 8'h00, 4, 1'b1);
    wb(mag_pkg::MAG_IDX_MEM_CTRL, 1'b1, 8'h01);
    acc(1'b1, 1'b1, 1'b0, {6'h00, p}, r[23:16], 4, 1'b0);
    wb(mag_pkg::MAG_IDX_MEM_CTRL, 1'b1, 8'h07);
    cyc_q.push_back(4'h2);
    acc(1'b1, 1'b1, 1'b1, {6'h00, p}, 8'h00, 0, 1'b0);
    $display("test bus modes done");
    // Port four pin functions, released pins as plain I/O
    wb(mag_pkg::MAG_IDX_P4_DATA, 1'b1, 8'hff);
    // Pin functions only change at the next access, so a random fetch follows each write
    for (int u = 0; u < 5; u++) begin
      hi_en = msk[u];
      lo_en = msk[u];
      wb(mag_pkg::MAG_IDX_P4_CFG, 1'b1, {2'b00, code[u], code[u]});
      r = rnd();
      acc(1'b0, 1'b0, 1'b0, r[21:0], 8'h00, 1, 1'b0);
      @(negedge core_clk_i);
      `CHK(port_four_oe_o, {msk[u], msk[u]})
    end
    wb(mag_pkg::MAG_IDX_P4_CFG, 1'b1, 8'h00);
    hi_en = 4'h0;
    lo_en = 4'h0;
    acc(1'b0, 1'b0, 1'b0, 22'h00_0000, 8'h00, 1, 1'b0);
    wb(mag_pkg::MAG_IDX_P4_DATA, 1'b1, 8'h00);
    @(negedge core_clk_i);
    `CHK(port_four_oe_o, 8'hff)
    `CHK(port_four_o, 8'h00)
    wb(mag_pkg::MAG_IDX_P4_CFG, 1'b1, 8'h3f);
    wb(mag_pkg::MAG_IDX_P4_DATA, 1'b1, 8'hff);
    $display("test port four done");
    // Dual data pointers
    wb(mag_pkg::MAG_IDX_DP0_LOW, 1'b1, 8'h34);
    wb(mag_pkg::MAG_IDX_DP0_HIGH, 1'b1, 8'h12);
    wb(mag_pkg::MAG_IDX_DP1_LOW, 1'b1, 8'hcd);
    wb(mag_pkg::MAG_IDX_DP1_HIGH, 1'b1, 8'hab);
    wb(mag_pkg::MAG_IDX_PTR_SEL, 1'b1, 8'hff);
    rd(mag_pkg::MAG_IDX_PTR_SEL, 8'hc1);
    @(negedge core_clk_i);
    `CHK(active_pointer_o, 16'habcd)
    pulse(1'b0);
    `CHK(active_pointer_o, 16'habcc)
    rd(mag_pkg::MAG_IDX_DP0_LOW, 8'h34);
    pulse(1'b1);
    rd(mag_pkg::MAG_IDX_PTR_SEL, 8'hc0);
    `CHK(active_pointer_o, 16'h1234)
    pulse(1'b0);
    `CHK(active_pointer_o, 16'h1233)
    wb(mag_pkg::MAG_IDX_PTR_SEL, 1'b1, 8'h00);
    pulse(1'b0);
    `CHK(active_pointer_o, 16'h1234)
    rd(mag_pkg::MAG_IDX_DP1_HIGH, 8'hab);
    $display("test pointers done");
    // Extended stack and its lockout in shared memory mode
    wb(mag_pkg::MAG_IDX_SP_HIGH, 1'b1, 8'hfe);
    wb(mag_pkg::MAG_IDX_SP_LOW, 1'b1, 8'h34);
    @(negedge core_clk_i);
    `CHK(stack_addr_o, 10'h034)
    wb(mag_pkg::MAG_IDX_ADDR_CTRL, 1'b1, 8'h04);
    @(negedge core_clk_i);
    `CHK(stack_in_data_mem_o, 1'b1)
    `CHK(stack_addr_o, 10'h234)
    wb(mag_pkg::MAG_IDX_MEM_CTRL, 1'b1, 8'h19);
    @(negedge core_clk_i);
    `CHK(stack_in_data_mem_o, 1'b0)
    wb(mag_pkg::MAG_IDX_ADDR_CTRL, 1'b1, 8'h04);
    rd(mag_pkg::MAG_IDX_ADDR_CTRL, 8'h00);
    $display("test stack done");
    repeat (2) @(negedge core_clk_i);
    wrap_up();
  end
endmodule
